//--- hw/ftb_nv_store.sv
// Nonvolatile word store, kept across reset, registered read
`timescale 1ns/1ns
module ftb_nv_store (
    input  wire logic        pclk,
    input  wire logic        we,
    input  wire logic [23:0] wdata,
    output logic      [23:0] rdata
);
    logic [23:0] mem_q;

    // No reset on purpose: contents outlive a reset like flash would
    always_ff @(posedge pclk) begin
        if (we) begin
            mem_q <= wdata;
        end
    end

    // Read word from a register
    always_ff @(posedge pclk) begin
        rdata <= mem_q;
    end
endmodule : ftb_nv_store

//--- hw/ftb_sync3.sv
// Three-stage pin synchroniser, per bit
`timescale 1ns/1ns
module ftb_sync3 #(
    parameter int unsigned W = 64
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] sync_out
);
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic s1_q;
            logic s2_q;
            logic s3_q;
            // Output moves only once stages two and three agree
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    s1_q        <= 1'b0;
                    s2_q        <= 1'b0;
                    s3_q        <= 1'b0;
                    sync_out[i] <= 1'b0;
                end else begin
                    s1_q <= pin_in[i];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                    if (s2_q == s3_q) begin
                        sync_out[i] <= s3_q;
                    end
                end
            end
        end
    endgenerate
endmodule : ftb_sync3

//--- hw/ftb_totalizer.sv
// Totalizer, elapsed timer, tare and batch control with APB registers
//
// What this block does
// R1 - Sample readings 1000 per second, refresh displayed values 10 per second.
// R2 - With autotare on, tare flow after zero setpoint held over delay.
// R3 - Autotare delay in seconds is configurable; autotare enabled by default.
// R4 - Tare captures flow zero; pressure tare captures gauge pressure offset.
// R5 - Flag a reading red above 128 percent of full scale.
// R6 - Accumulate total since reset, limited to seven digits.
// R7 - Rollover mode (default) restarts total from zero at maximum.
// R8 - Freeze mode holds total at maximum until reset.
// R9 - Error option raises overflow flag at maximum, either mode.
// R10 - Elapsed time counts to 9999:59:59 then holds.
// R11 - Totalizer reset clears total and timer; next batch starts at once.
// R12 - Batch runs with nonzero batch size and nonzero setpoint.
// R13 - During a batch, report batch size minus total as remaining.
// R14 - Total reaching batch size closes valve and flags done.
// R15 - Batch size change: flow continues if above total, else stops.
// R16 - Zero setpoint pauses batch flow; timer keeps running.
// R17 - Clearing batch size leaves setpoint, flow resumes at setpoint.
// R18 - Batch size kept in nonvolatile storage until cleared.
// R19 - Over-range flow adds clamped rate, flashes total, sets missed flag.
// R20 - Knob setpoint accepted only with analog setpoint source.
// R21 - Operator tares flow with no flow, pressure when vented.
// R22 - Each sample adds flow rate times sample interval to total.
//
// Chosen here: the address map and register access over APB.
`timescale 1ns/1ns
module ftb_totalizer #(
    parameter int unsigned SAMPLE_CYC = ftb_pkg::SAMPLE_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [15:0] flow_raw,
    input  wire logic [15:0] pres_raw,
    input  wire logic [15:0] temp_raw,
    input  wire logic [15:0] setpoint_knob,
    output logic             valve_open,
    output logic      [15:0] valve_setpoint,
    output logic             batch_done,
    output logic             total_overflow_flag,
    output logic             missed_flow_flag,
    output logic             total_flash,
    output logic             red_flow,
    output logic             red_pres,
    output logic             red_temp
);
    logic [63:0] pins_s;
    logic [15:0] flow_s;
    logic [15:0] pres_s;
    logic [15:0] temp_s;
    logic [15:0] knob_s;
    logic [ftb_pkg::CYC_W-1:0] cyc_q;
    logic        smp_tick;
    logic [9:0]  ms_q;
    logic        sec_tick;
    logic [6:0]  dsp_cnt_q;
    logic        dsp_tick;
    logic        blink_q;
    logic [3:0]  ctrl_q;
    logic [7:0]  delay_q;
    logic [15:0] setpt_q;
    logic [15:0] sp;
    logic        sp_nz;
    logic        wr;
    logic        rd_setup;
    logic        cmd_wr;
    logic        trst;
    logic        ftare;
    logic        ptare;
    logic        atare;
    logic [15:0] flow_q;
    logic [15:0] pres_q;
    logic [15:0] temp_q;
    logic [15:0] fzero_q;
    logic [15:0] pzero_q;
    logic [15:0] flow_t;
    logic [15:0] pres_t;
    logic [15:0] dflow_q;
    logic [15:0] dpres_q;
    logic [15:0] dtemp_q;
    logic [17:0] zs_ms_q;
    logic [17:0] zs_lim;
    logic        zs_done_q;
    logic [23:0] total_q;
    logic [24:0] sum;
    logic        over;
    logic [15:0] add;
    logic [5:0]  sec_q;
    logic [5:0]  min_q;
    logic [13:0] hr_q;
    logic        t_full;
    logic [23:0] batch;
    logic        bat_nz;
    logic        reached;
    logic [23:0] remain;
    logic [31:0] rd_d;
    logic        err_d;
    ftb_pkg::ftb_bstate_t st_q;
    ftb_pkg::ftb_bstate_t st_d;

    // Pin inputs from the sensor converters and the knob
    ftb_sync3 #(
        .W (64)
    ) u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .pin_in   ({flow_raw, pres_raw, temp_raw, setpoint_knob}),
        .sync_out (pins_s)
    );
    assign flow_s = pins_s[63:48];
    assign pres_s = pins_s[47:32];
    assign temp_s = pins_s[31:16];
    assign knob_s = pins_s[15:0];

    // Batch size lives in the store that survives reset
    ftb_nv_store u_nv (
        .pclk  (pclk),
        .we    (wr && paddr == ftb_pkg::A_BATCH), // R18
        .wdata (pwdata[23:0]),
        .rdata (batch)
    );

    // Sample divider, one enable pulse per millisecond
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cyc_q <= '0;
        end else if (smp_tick) begin
            cyc_q <= '0;
        end else begin
            cyc_q <= cyc_q + 1'b1;
        end
    end
    assign smp_tick = (cyc_q == ftb_pkg::CYC_W'(SAMPLE_CYC - 1)); // R1

    // Seconds and display-refresh dividers from the sample pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ms_q      <= '0;
            dsp_cnt_q <= '0;
            blink_q   <= 1'b0;
        end else if (smp_tick) begin
            ms_q      <= sec_tick ? 10'h000 : ms_q + 1'b1;
            dsp_cnt_q <= dsp_tick ? 7'h00 : dsp_cnt_q + 1'b1; // R1
            if (dsp_tick) begin
                blink_q <= ~blink_q;
            end
        end
    end
    assign sec_tick = smp_tick && ms_q == ftb_pkg::SMP_PER_SEC;
    assign dsp_tick = smp_tick && dsp_cnt_q == ftb_pkg::SMP_PER_DSP;

    // APB strobes; access phase always answers in its first cycle
    assign wr       = psel && penable && pwrite;
    assign rd_setup = psel && !penable;
    assign pready   = psel && penable;
    assign cmd_wr   = wr && paddr == ftb_pkg::A_CMD;
    assign trst     = cmd_wr && pwdata[ftb_pkg::K_TRST];
    assign ftare    = (cmd_wr && pwdata[ftb_pkg::K_FTARE]) || atare; // R4
    assign ptare    = cmd_wr && pwdata[ftb_pkg::K_PTARE]; // R4

    // Configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q  <= ftb_pkg::CTRL_RST; // R3
            delay_q <= ftb_pkg::DELAY_RST; // R3
            setpt_q <= 16'h0000;
        end else if (wr) begin
            if (paddr == ftb_pkg::A_CTRL) begin
                ctrl_q <= pwdata[3:0];
            end else if (paddr == ftb_pkg::A_DELAY) begin
                delay_q <= pwdata[7:0];
            end else if (paddr == ftb_pkg::A_SETPT && !ctrl_q[ftb_pkg::C_ANALOG]) begin
                setpt_q <= pwdata[15:0]; // Bus setpoint ignored in analog mode
            end
        end
    end

    // Knob drives the setpoint only in analog mode
    assign sp    = ctrl_q[ftb_pkg::C_ANALOG] ? knob_s : setpt_q; // R20
    assign sp_nz = sp != 16'h0000;

    // Live samples taken once per millisecond
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flow_q <= 16'h0000;
            pres_q <= 16'h0000;
            temp_q <= 16'h0000;
        end else if (smp_tick) begin
            flow_q <= flow_s; // R1
            pres_q <= pres_s;
            temp_q <= temp_s;
        end
    end

    // Zero references; flow tare assumes the line is still (R21)
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fzero_q <= 16'h0000;
            pzero_q <= 16'h0000;
        end else begin
            if (ftare) begin
                fzero_q <= flow_q; // R4
            end
            if (ptare) begin
                pzero_q <= pres_q; // R4
            end
        end
    end
    // Clamp at zero so a stale tare never wraps negative
    assign flow_t = flow_q > fzero_q ? flow_q - fzero_q : 16'h0000;
    assign pres_t = pres_q > pzero_q ? pres_q - pzero_q : 16'h0000;

    // Autotare: zero setpoint held strictly longer than the delay
    assign zs_lim = 18'(delay_q * ftb_pkg::MS_PER_S);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            zs_ms_q   <= 18'h00000;
            zs_done_q <= 1'b0;
        end else if (sp_nz || !ctrl_q[ftb_pkg::C_ATARE]) begin
            zs_ms_q   <= 18'h00000;
            zs_done_q <= 1'b0;
        end else if (smp_tick && !zs_done_q) begin
            zs_ms_q   <= zs_ms_q + 1'b1; // R3
            zs_done_q <= zs_ms_q > zs_lim; // R2
        end
    end
    // One tare per zero-setpoint episode
    assign atare = smp_tick && !zs_done_q && zs_ms_q > zs_lim; // R2

    // Display copies refreshed ten times a second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dflow_q <= 16'h0000;
            dpres_q <= 16'h0000;
            dtemp_q <= 16'h0000;
        end else if (dsp_tick) begin
            dflow_q <= flow_t; // R1
            dpres_q <= pres_t;
            dtemp_q <= temp_q;
        end
    end

    // Red indication above 128 percent of full scale
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            red_flow <= 1'b0;
            red_pres <= 1'b0;
            red_temp <= 1'b0;
        end else begin
            red_flow <= dflow_q > ftb_pkg::LIM_FLOW; // R5
            red_pres <= dpres_q > ftb_pkg::LIM_PRES; // R5
            red_temp <= dtemp_q > ftb_pkg::LIM_TEMP; // R5
        end
    end

    // Increment: rate per sample, clamped when over range
    assign over = flow_t > ftb_pkg::LIM_FLOW;
    assign add  = over ? ftb_pkg::LIM_FLOW : flow_t; // R19
    assign sum  = {1'b0, total_q} + {9'h000, add}; // R22

    // Seven-digit total; reset command outranks a sample
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            total_q <= 24'h000000;
        end else if (trst) begin
            total_q <= 24'h000000; // R11
        end else if (smp_tick) begin
            if (sum <= {1'b0, ftb_pkg::TOTAL_MAX}) begin
                total_q <= sum[23:0]; // R6
            end else if (ctrl_q[ftb_pkg::C_FREEZE]) begin
                total_q <= ftb_pkg::TOTAL_MAX; // R8
            end else begin
                total_q <= 24'(sum - {1'b0, ftb_pkg::TOTAL_MAX} - 25'h1); // R7
            end
        end
    end

    // Sticky flags; a new event in the reset cycle still sets
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            total_overflow_flag <= 1'b0;
            missed_flow_flag    <= 1'b0;
        end else begin
            if (smp_tick && ctrl_q[ftb_pkg::C_ERR] && sum >= {1'b0, ftb_pkg::TOTAL_MAX}) begin
                total_overflow_flag <= 1'b1; // R9
            end else if (trst) begin
                total_overflow_flag <= 1'b0;
            end
            if (smp_tick && over) begin
                missed_flow_flag <= 1'b1; // R19
            end else if (trst) begin
                missed_flow_flag <= 1'b0; // R19
            end
        end
    end

    // Flashing total while flow was missed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            total_flash <= 1'b0;
        end else begin
            total_flash <= missed_flow_flag && blink_q; // R19
        end
    end

    // Elapsed time h:m:s, independent of setpoint and valve (R16)
    assign t_full = hr_q == ftb_pkg::HOURS_MAX && min_q == ftb_pkg::MS_MAX
                    && sec_q == ftb_pkg::MS_MAX;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sec_q <= 6'h00;
            min_q <= 6'h00;
            hr_q  <= 14'h0000;
        end else if (trst) begin
            sec_q <= 6'h00; // R11
            min_q <= 6'h00;
            hr_q  <= 14'h0000;
        end else if (sec_tick && !t_full) begin // R10
            if (sec_q != ftb_pkg::MS_MAX) begin
                sec_q <= sec_q + 1'b1;
            end else begin
                sec_q <= 6'h00;
                if (min_q != ftb_pkg::MS_MAX) begin
                    min_q <= min_q + 1'b1;
                end else begin
                    min_q <= 6'h00;
                    hr_q  <= hr_q + 1'b1;
                end
            end
        end
    end

    // Batch conditions; a shrunk size is caught by the compare
    assign bat_nz  = batch != 24'h000000; // R12
    assign reached = total_q >= batch; // R15

    // Batch sequencer
    always_comb begin
        st_d = st_q;
        case (st_q)
            ftb_pkg::B_OFF: begin
                if (bat_nz) begin
                    st_d = ftb_pkg::B_PAUSE;
                end
            end
            ftb_pkg::B_PAUSE: begin
                if (!bat_nz) begin
                    st_d = ftb_pkg::B_OFF;
                end else if (reached) begin
                    st_d = ftb_pkg::B_DONE;
                end else if (sp_nz) begin
                    st_d = ftb_pkg::B_RUN; // R12
                end
            end
            ftb_pkg::B_RUN: begin
                if (!bat_nz) begin
                    st_d = ftb_pkg::B_OFF; // R17
                end else if (reached) begin
                    st_d = ftb_pkg::B_DONE; // R14
                end else if (!sp_nz) begin
                    st_d = ftb_pkg::B_PAUSE; // R16
                end
            end
            ftb_pkg::B_DONE: begin
                if (!bat_nz) begin
                    st_d = ftb_pkg::B_OFF;
                end else if (!reached) begin
                    st_d = sp_nz ? ftb_pkg::B_RUN : ftb_pkg::B_PAUSE; // R11
                end
            end
            default: begin
                st_d = ftb_pkg::B_OFF;
            end
        endcase
    end

    // State register; batch size itself persists in the store (R18)
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= ftb_pkg::B_OFF;
        end else begin
            st_q <= st_d;
        end
    end

    // Valve command: plain setpoint without a batch, else only when running
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            valve_open     <= 1'b0;
            valve_setpoint <= 16'h0000;
            batch_done     <= 1'b0;
        end else begin
            valve_open     <= (st_d == ftb_pkg::B_RUN) || (st_d == ftb_pkg::B_OFF && sp_nz); // R17
            valve_setpoint <= (st_d == ftb_pkg::B_RUN || st_d == ftb_pkg::B_OFF) ? sp : 16'h0000;
            batch_done     <= st_d == ftb_pkg::B_DONE; // R14
        end
    end

    // Remaining quantity replaces batch size while in progress
    assign remain = (st_q == ftb_pkg::B_RUN || st_q == ftb_pkg::B_PAUSE)
                    ? batch - total_q : batch; // R13

    // Read decode
    always_comb begin
        rd_d  = 32'h00000000;
        err_d = 1'b0;
        if (paddr == ftb_pkg::A_CTRL) begin
            rd_d = {28'h0000000, ctrl_q};
        end else if (paddr == ftb_pkg::A_DELAY) begin
            rd_d = {24'h000000, delay_q};
        end else if (paddr == ftb_pkg::A_SETPT) begin
            rd_d = {16'h0000, sp};
        end else if (paddr == ftb_pkg::A_BATCH) begin
            rd_d = {8'h00, batch};
        end else if (paddr == ftb_pkg::A_CMD) begin
            rd_d = 32'h00000000;
        end else if (paddr == ftb_pkg::A_TOTAL) begin
            rd_d = {8'h00, total_q};
        end else if (paddr == ftb_pkg::A_TIME) begin
            rd_d = {6'h00, hr_q, min_q, sec_q};
        end else if (paddr == ftb_pkg::A_STAT) begin
            rd_d = {23'h000000, total_flash, red_temp, red_pres, red_flow,
                    st_q == ftb_pkg::B_RUN || st_q == ftb_pkg::B_PAUSE,
                    valve_open, batch_done, missed_flow_flag, total_overflow_flag};
        end else if (paddr == ftb_pkg::A_REMAIN) begin
            rd_d = {8'h00, remain};
        end else if (paddr == ftb_pkg::A_FLOW) begin
            rd_d = {16'h0000, dflow_q};
        end else if (paddr == ftb_pkg::A_PRES) begin
            rd_d = {16'h0000, dpres_q};
        end else if (paddr == ftb_pkg::A_TEMP) begin
            rd_d = {16'h0000, dtemp_q};
        end else begin
            err_d = 1'b1;
        end
    end

    // Read data and error captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (rd_setup) begin
            prdata  <= pwrite ? 32'h00000000 : rd_d;
            pslverr <= err_d;
        end
    end
endmodule : ftb_totalizer

//--- pkg/ftb_pkg.sv
// Constants shared by the flow totalizer and batch controller
package ftb_pkg;
    // Clock and sample rates
    localparam int unsigned CLK_HZ      = 20_000_000;
    localparam int unsigned SAMPLE_HZ   = 1000;
    localparam int unsigned DISP_HZ     = 10;
    localparam int unsigned SAMPLE_CYC  = CLK_HZ / SAMPLE_HZ;
    localparam int unsigned CYC_W       = 15;
    localparam logic [9:0]  SMP_PER_SEC = 10'(SAMPLE_HZ - 1);
    localparam logic [6:0]  SMP_PER_DSP = 7'(SAMPLE_HZ / DISP_HZ - 1);
    localparam logic [9:0]  MS_PER_S    = 10'(SAMPLE_HZ);

    // Readings and over-range limit at 128 percent of full scale
    localparam int unsigned RW         = 16;
    localparam int unsigned OVR_PCT    = 128;
    localparam logic [15:0] FS_FLOW    = 16'h2710;
    localparam logic [15:0] FS_PRES    = 16'h2710;
    localparam logic [15:0] FS_TEMP    = 16'h2710;
    localparam logic [15:0] LIM_FLOW   = 16'(32'(FS_FLOW) * OVR_PCT / 100);
    localparam logic [15:0] LIM_PRES   = 16'(32'(FS_PRES) * OVR_PCT / 100);
    localparam logic [15:0] LIM_TEMP   = 16'(32'(FS_TEMP) * OVR_PCT / 100);

    // Seven-digit total and elapsed-time limits
    localparam int unsigned TW        = 24;
    localparam logic [23:0] TOTAL_MAX = 24'h98967F;
    localparam logic [13:0] HOURS_MAX = 14'h270F;
    localparam logic [5:0]  MS_MAX    = 6'h3B;

    // Register byte addresses
    localparam logic [7:0] A_CTRL   = 8'h00;
    localparam logic [7:0] A_DELAY  = 8'h04;
    localparam logic [7:0] A_SETPT  = 8'h08;
    localparam logic [7:0] A_BATCH  = 8'h0C;
    localparam logic [7:0] A_CMD    = 8'h10;
    localparam logic [7:0] A_TOTAL  = 8'h14;
    localparam logic [7:0] A_TIME   = 8'h18;
    localparam logic [7:0] A_STAT   = 8'h1C;
    localparam logic [7:0] A_REMAIN = 8'h20;
    localparam logic [7:0] A_FLOW   = 8'h24;
    localparam logic [7:0] A_PRES   = 8'h28;
    localparam logic [7:0] A_TEMP   = 8'h2C;

    // Control fields and reset values
    localparam int unsigned C_FREEZE  = 0;
    localparam int unsigned C_ERR     = 1;
    localparam int unsigned C_ATARE   = 2;
    localparam int unsigned C_ANALOG  = 3;
    localparam logic [3:0]  CTRL_RST  = 4'h6;
    localparam logic [7:0]  DELAY_RST = 8'h02;

    // Command bits, write one to act
    localparam int unsigned K_TRST  = 0;
    localparam int unsigned K_FTARE = 1;
    localparam int unsigned K_PTARE = 2;

    // Status bits
    localparam int unsigned S_OVF   = 0;
    localparam int unsigned S_MISS  = 1;
    localparam int unsigned S_DONE  = 2;
    localparam int unsigned S_VALVE = 3;
    localparam int unsigned S_ACT   = 4;
    localparam int unsigned S_REDF  = 5;
    localparam int unsigned S_REDP  = 6;
    localparam int unsigned S_REDT  = 7;
    localparam int unsigned S_FLASH = 8;

    // Batch states
    typedef enum logic [3:0] {
        B_OFF   = 4'h1,
        B_PAUSE = 4'h2,
        B_RUN   = 4'h4,
        B_DONE  = 4'h8
    } ftb_bstate_t;
endpackage : ftb_pkg

//--- tb/ftb_totalizer_checker.sv
// Port checks for the totalizer block
`timescale 1ns/1ns
module ftb_totalizer_chk (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        valve_open,
    input wire logic        batch_done,
    input wire logic        total_overflow_flag,
    input wire logic        missed_flow_flag,
    input wire logic        total_flash
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Reset command write; the clear may land a cycle late
    logic clr;
    assign clr = psel && penable && pwrite && paddr == 8'h10 && pwdata[0];

    pready_on_a: assert property (psel && penable |-> pready)
        else $error("pready missing in access");
    pready_off_a: assert property (psel && !penable |-> !pready)
        else $error("pready in setup");
    bad_addr_a: assert property (psel && penable && paddr > 8'h2C |-> pslverr)
        else $error("unmapped without error");
    good_addr_a: assert property (psel && penable && paddr < 8'h30 && paddr[1:0] == 2'b00
        |-> !pslverr) else $error("mapped with error");
    ovf_hold_a: assert property (total_overflow_flag && !clr && !$past(clr)
        |=> total_overflow_flag) else $error("overflow flag dropped");
    miss_hold_a: assert property (missed_flow_flag && !clr && !$past(clr)
        |=> missed_flow_flag) else $error("missed flag dropped");
    flash_gate_a: assert property (!missed_flow_flag [*2] |-> !total_flash)
        else $error("flash without missed flow");
    done_shut_a: assert property (batch_done [*2] |-> !valve_open)
        else $error("valve open after done");
endmodule : ftb_totalizer_chk

bind ftb_totalizer ftb_totalizer_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .pslverr, .valve_open, .batch_done, .total_overflow_flag,
    .missed_flow_flag, .total_flash);

//--- tb/ftb_valve_model.sv
// Valve and flow sensor stand-in
`timescale 1ns/1ns
module ftb_valve_model (
    input  wire logic        pclk,
    input  wire logic        valve_open,
    input  wire logic [15:0] rate,
    output logic      [15:0] flow_raw
);
    // Closed valve gives true zero flow, so a tare then is clean
    always_ff @(posedge pclk) begin
        flow_raw <= valve_open ? rate : 16'h0000;
    end
endmodule : ftb_valve_model

//--- tb/tb.sv
// Register-level bench for the totalizer
`timescale 1ns/1ns
module tb;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, sl;
    logic        valve_open, batch_done, ovf, miss, red_flow, red_pres, red_temp, flash;
    logic [7:0]  paddr;
    logic [15:0] rate, flow_raw, pres_raw, vsp;
    logic [31:0] pwdata, prdata, rdat;
    int          errors, num_checks;

    ftb_totalizer #(.SAMPLE_CYC(20)) dut (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .flow_raw, .pres_raw,
        .temp_raw(16'h0000), .setpoint_knob(16'h0050), .valve_open,
        .valve_setpoint(vsp), .batch_done, .total_overflow_flag(ovf),
        .missed_flow_flag(miss), .total_flash(flash), .red_flow, .red_pres, .red_temp);
    ftb_valve_model pm (.pclk, .valve_open, .rate, .flow_raw);

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // One APB transfer, held until pready is seen at an edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdat = prdata;
        sl = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
        xfer(1'b0, a, 32'h0);
        chk(nm, rdat, exp);
    endtask : rd
    task automatic conclude();
        if (errors == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : conclude

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    // Two long totalizer runs dominate the run time
    initial begin
        repeat (60000) @(posedge pclk);
        errors++;
        conclude();
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        rate = 16'h0000;
        pres_raw = 16'h0000;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rd(8'h00, 32'h6, "ctrl");
        rd(8'h04, 32'h2, "delay");
        xfer(1'b0, 8'h40, 32'h0);
        chk("slverr", sl, 1);
        xfer(1'b1, 8'h0C, 32'h0);
        xfer(1'b1, 8'h0C, 32'h3E8);
        rd(8'h0C, 32'h3E8, "batch");
        rate <= 16'h0064;
        xfer(1'b1, 8'h08, 32'h64);
        for (int i = 0; i < 400 && batch_done !== 1'b1; i++) @(posedge pclk);
        repeat (2) @(posedge pclk);
        chk("done", batch_done, 1);
        chk("valve", valve_open, 0);
        chk("vsp done", vsp, 0);
        rd(8'h14, 32'h3E8, "total");
        xfer(1'b1, 8'h10, 32'h1);
        rd(8'h14, 32'h0, "total clr");
        rd(8'h18, 32'h0, "time clr");
        for (int i = 0; i < 10 && valve_open !== 1'b1; i++) @(posedge pclk);
        chk("restart", valve_open, 1);
        xfer(1'b1, 8'h08, 32'h0);
        repeat (4) @(posedge pclk);
        chk("pause", valve_open, 0);
        xfer(1'b1, 8'h08, 32'h64);
        xfer(1'b1, 8'h0C, 32'h0);
        repeat (4) @(posedge pclk);
        chk("no batch", valve_open, 1);
        chk("vsp", vsp, 32'h64);
        // Freeze with error option, flow clamped at the over-range limit
        xfer(1'b1, 8'h00, 32'h3);
        rate <= 16'hFFFF;
        pres_raw <= 16'h3201;
        xfer(1'b1, 8'h10, 32'h1);
        repeat (16400) @(posedge pclk);
        rd(8'h14, 32'h98967F, "frozen");
        chk("ovf", ovf, 1);
        chk("miss", miss, 1);
        chk("red f", red_flow, 1);
        chk("red p", red_pres, 1);
        chk("red t", red_temp, 0);
        for (int i = 0; i < 4100 && flash !== 1'b1; i++) @(posedge pclk);
        chk("flash", flash, 1);
        rate <= 16'h0000;
        repeat (30) @(posedge pclk);
        xfer(1'b1, 8'h10, 32'h1);
        xfer(1'b1, 8'h10, 32'h1);
        repeat (2) @(posedge pclk);
        chk("ovf clr", ovf, 0);
        chk("miss clr", miss, 0);
        // Rollover: past the limit the total wraps far below it
        xfer(1'b1, 8'h00, 32'h2);
        rate <= 16'hFFFF;
        xfer(1'b1, 8'h10, 32'h1);
        repeat (16400) @(posedge pclk);
        xfer(1'b0, 8'h14, 32'h0);
        chk("wrapped", rdat < 32'h000F4240 && rdat != 32'h0, 1);
        chk("ovf roll", ovf, 1);
        xfer(1'b1, 8'h00, 32'h8);
        repeat (25) @(posedge pclk);
        rd(8'h08, 32'h50, "knob");
        conclude();
    end
endmodule : tb
